//--- hw/port_regs_defs.svh
// register offsets, field positions and reset values of the port 0 bank
// assumes an 8-bit register space reached by a simple strobe port
`ifndef PORT_REGS_DEFS_SVH
`define PORT_REGS_DEFS_SVH

`define LINE_IFACE_LOCK_STATUS_ADDR     8'h81
`define OPTICAL_MODULE_CTRL_STATUS_ADDR 8'h83
`define PORT_CLOCK_ENABLE_ADDR          8'h84
`define RX_FRAMING_CTRL_ADDR            8'h85
`define RX_FILTER_CTRL_ADDR             8'h86
`define TEST_SOURCE_SELECT_ADDR         8'h89
`define FRAME_COUNTER_CTRL_ADDR         8'h8B

// transceiver register bits
`define XCVR_SIGNAL_LOST_BIT 7
`define XCVR_FAULT_BIT       6
`define XCVR_PRESENT_BIT     5
`define XCVR_LASER_OFF_BIT   0

// writable masks per register
`define XCVR_WR_MASK   8'h01
`define ENABLE_WR_MASK 8'h13
`define FRAMING_WR_MASK 8'h0F
`define FILTER_WR_MASK 8'h08
`define TESTSRC_WR_MASK 8'hEE
`define CNTCTL_WR_MASK 8'h81

// reset values of the writable registers
`define XCVR_RESET    8'h00
`define ENABLE_RESET  8'h00
`define FRAMING_RESET 8'h00
`define FILTER_RESET  8'h00
`define TESTSRC_RESET 8'h00
`define CNTCTL_RESET  8'h00

// debug packet payload counter range
`define DEBUG_COUNT_FIRST 8'h00
`define DEBUG_COUNT_LAST  8'h95

`endif

//--- hw/port_regs_pkg.sv
// types shared by the port 0 control and status bank
// assumes the constants header is included by the design file
package port_regs_pkg;

   typedef enum logic [1:0]
   {
      TXSRC_NORMAL      = 2'b00,
      TXSRC_DEBUG_PCS   = 2'b01,
      TXSRC_DEBUG_NOPCS = 2'b10,
      TXSRC_NORMAL_ALT  = 2'b11
   } tx_src_e;

   typedef struct packed
   {
      logic [7:0] xcvr;
      logic [7:0] enable;
      logic [7:0] framing;
      logic [7:0] filter;
      logic [7:0] testsrc;
      logic [7:0] cntctl;
      logic [7:0] rdata;
      logic [7:0] dbg_count;
      logic [2:0] s_line_tx;
      logic [2:0] s_line_rx;
      logic [2:0] s_los;
      logic [2:0] s_fault;
      logic [2:0] s_pres;
      logic [2:0] s_txl;
      logic [2:0] s_rxl;
      logic [2:0] s_sysl;
      logic [2:0] s_sh;
      logic [2:0] s_hber;
      logic [9:0] st;
   } regs_s;

endpackage : port_regs_pkg

//--- hw/port_ctrl_status.sv
// control and status bank for the 10 Gb/s port 0
// assumes status inputs are asynchronous pins; strobe bus on sys_clk
//
// What this block does
// RULE1: line status: tx lock bit1, rx lock bit0
// RULE2: transceiver reads signal lost, fault, present
// RULE3: laser off bit disables module transmitter
// RULE4: enable reg bits 7..5 show pll locks
// RULE5: enable bit4 clear resets rx clock manager
// RULE6: enable bit1 clear resets tx clock manager
// RULE7: enable bit0 clear resets line interface
// RULE8: link good = sync found and not high ber
// RULE9: framing bit6 shows sync header found
// RULE10: framing bit5 shows high error rate
// RULE11: source field: 00 off, 01 fifo, 1x test
// RULE12: bit1 gates collection until link established
// RULE13: software pulses bit0 to restart sync
// RULE14: filter bit3 stops idle removal
// RULE15: select bit7 substitutes prbs15 rx data
// RULE16: select bit6 sends debug counter packets
// RULE17: select bit5 routes ddr2 fifo to tx
// RULE18: select bit3 transmits prbs
// RULE19: tx debug field picks data source
// RULE20: counter bit7 enables, clear resets counters
// RULE21: counter bit0 freezes counter values
// RULE22: read-only and reserved bit writes ignored
//
// Design decision made here: the plain strobed port.
`include "port_regs_defs.svh"

module port_ctrl_status
(
   input  wire logic       sys_clk,
   input  wire logic       srst,
   input  wire logic [7:0] addr,
   input  wire logic [7:0] wdata,
   input  wire logic       wr,
   input  wire logic       rd,
   output logic      [7:0] rdata,
   input  wire logic       line_tx_pll_locked,
   input  wire logic       line_rx_pll_locked,
   input  wire logic       module_signal_lost,
   input  wire logic       module_fault,
   input  wire logic       module_present,
   input  wire logic       tx_clock_locked,
   input  wire logic       rx_clock_locked,
   input  wire logic       system_clock_locked,
   input  wire logic       sync_header_locked,
   input  wire logic       high_error_rate,
   output logic            module_laser_off,
   output logic            rx_clock_mgr_run,
   output logic            tx_clock_mgr_run,
   output logic            line_iface_run,
   output logic            link_established,
   output logic      [1:0] rx_buffer_source,
   output logic            rx_fifo_enable,
   output logic            rx_test_mode,
   output logic            collect_gated,
   output logic            frame_sync_restart,
   output logic            idle_filter_off,
   output logic            rx_pattern_substitute,
   output logic            tx_debug_packets,
   output logic      [7:0] debug_payload,
   output logic            ddr_fifo_to_tx,
   output logic            tx_pattern_on,
   output logic      [1:0] tx_debug_source,
   output logic            tx_debug_via_pcs,
   output logic            tx_debug_bypass_pcs,
   output logic            err_count_enable,
   output logic            err_count_hold
);

   // **************************************************
   // decode helpers
   // **************************************************
   // a pin change counts once stages two and three agree
   function automatic logic settled(input logic [2:0] s, input logic prev);
      settled = (s[1] == s[2]) ? s[2] : prev;
   endfunction : settled

   function automatic logic [7:0] merge
   (
      input logic [7:0] old,
      input logic [7:0] din,
      input logic [7:0] mask
   );
      merge = (old & ~mask) | (din & mask);
   endfunction : merge

   port_regs_pkg::regs_s q;
   port_regs_pkg::regs_s next_q;

   // filtered pin states, held so a stage mismatch keeps the old value
   logic [9:0] flt;
   logic [9:0] raw;

   assign raw = {high_error_rate, sync_header_locked, system_clock_locked,
                 rx_clock_locked, tx_clock_locked, module_present,
                 module_fault, module_signal_lost, line_rx_pll_locked,
                 line_tx_pll_locked};

   // flt is simply the stored filtered state
   assign flt = q.st;

   // **************************************************
   // next state
   // **************************************************
   always_comb
   begin
      logic [7:0] rv;
      logic       link;
      rv     = 8'h00;
      link   = flt[8] & ~flt[9]; // RULE8
      next_q = q;
      // three-stage synchronisers, first stage read only by the second
      next_q.s_line_tx = {q.s_line_tx[1:0], raw[0]};
      next_q.s_line_rx = {q.s_line_rx[1:0], raw[1]};
      next_q.s_los     = {q.s_los[1:0],     raw[2]};
      next_q.s_fault   = {q.s_fault[1:0],   raw[3]};
      next_q.s_pres    = {q.s_pres[1:0],    raw[4]};
      next_q.s_txl     = {q.s_txl[1:0],     raw[5]};
      next_q.s_rxl     = {q.s_rxl[1:0],     raw[6]};
      next_q.s_sysl    = {q.s_sysl[1:0],    raw[7]};
      next_q.s_sh      = {q.s_sh[1:0],      raw[8]};
      next_q.s_hber    = {q.s_hber[1:0],    raw[9]};
      next_q.st[0] = settled(q.s_line_tx, flt[0]);
      next_q.st[1] = settled(q.s_line_rx, flt[1]);
      next_q.st[2] = settled(q.s_los,     flt[2]);
      next_q.st[3] = settled(q.s_fault,   flt[3]);
      next_q.st[4] = settled(q.s_pres,    flt[4]);
      next_q.st[5] = settled(q.s_txl,     flt[5]);
      next_q.st[6] = settled(q.s_rxl,     flt[6]);
      next_q.st[7] = settled(q.s_sysl,    flt[7]);
      next_q.st[8] = settled(q.s_sh,      flt[8]);
      next_q.st[9] = settled(q.s_hber,    flt[9]);

      // only writable bits are stored; status bits are never written
      if (wr)
      begin
         case (addr)
            `OPTICAL_MODULE_CTRL_STATUS_ADDR:
               next_q.xcvr = merge(q.xcvr, wdata, `XCVR_WR_MASK); // RULE22
            `PORT_CLOCK_ENABLE_ADDR:
               next_q.enable = merge(q.enable, wdata, `ENABLE_WR_MASK);
            `RX_FRAMING_CTRL_ADDR:
               next_q.framing = merge(q.framing, wdata, `FRAMING_WR_MASK);
            `RX_FILTER_CTRL_ADDR:
               next_q.filter = merge(q.filter, wdata, `FILTER_WR_MASK);
            `TEST_SOURCE_SELECT_ADDR:
               next_q.testsrc = merge(q.testsrc, wdata, `TESTSRC_WR_MASK);
            `FRAME_COUNTER_CTRL_ADDR:
               next_q.cntctl = merge(q.cntctl, wdata, `CNTCTL_WR_MASK);
            default:
               next_q.rdata = q.rdata;
         endcase
      end

      // read data stands in the cycle after the strobe only
      if (rd)
      begin
         case (addr)
            `LINE_IFACE_LOCK_STATUS_ADDR:
               rv = {6'h00, flt[0], flt[1]}; // RULE1
            `OPTICAL_MODULE_CTRL_STATUS_ADDR:
               rv = {flt[2], flt[3], flt[4], 4'h0,
                     q.xcvr[`XCVR_LASER_OFF_BIT]}; // RULE2
            `PORT_CLOCK_ENABLE_ADDR:
               rv = {flt[5], flt[6], flt[7], q.enable[4:0]}; // RULE4
            `RX_FRAMING_CTRL_ADDR:
               rv = {link, flt[8], flt[9], 1'b0,
                     q.framing[3:0]}; // RULE9 RULE10
            `RX_FILTER_CTRL_ADDR:
               rv = q.filter;
            `TEST_SOURCE_SELECT_ADDR:
               rv = q.testsrc;
            `FRAME_COUNTER_CTRL_ADDR:
               rv = q.cntctl;
            default:
               rv = 8'h00;
         endcase
      end
      next_q.rdata = rv;

      // debug packet payload wraps after the last count
      if (!q.testsrc[6])
         next_q.dbg_count = `DEBUG_COUNT_FIRST;
      else if (q.dbg_count == `DEBUG_COUNT_LAST)
         next_q.dbg_count = `DEBUG_COUNT_FIRST; // RULE16
      else
         next_q.dbg_count = q.dbg_count + 8'h01;
   end

   // **************************************************
   // state register
   // **************************************************
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         q         <= '0;
         q.xcvr    <= `XCVR_RESET;
         q.enable  <= `ENABLE_RESET;
         q.framing <= `FRAMING_RESET;
         q.filter  <= `FILTER_RESET;
         q.testsrc <= `TESTSRC_RESET;
         q.cntctl  <= `CNTCTL_RESET;
      end
      else
         q <= next_q;
   end

   // **************************************************
   // registered outputs
   // **************************************************
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         module_laser_off      <= 1'b0;
         rx_clock_mgr_run      <= 1'b0;
         tx_clock_mgr_run      <= 1'b0;
         line_iface_run        <= 1'b0;
         link_established      <= 1'b0;
         rx_buffer_source      <= 2'b00;
         rx_fifo_enable        <= 1'b0;
         rx_test_mode          <= 1'b0;
         collect_gated         <= 1'b0;
         frame_sync_restart    <= 1'b0;
         idle_filter_off       <= 1'b0;
         rx_pattern_substitute <= 1'b0;
         tx_debug_packets      <= 1'b0;
         debug_payload         <= 8'h00;
         ddr_fifo_to_tx        <= 1'b0;
         tx_pattern_on         <= 1'b0;
         tx_debug_source       <= 2'b00;
         tx_debug_via_pcs      <= 1'b0;
         tx_debug_bypass_pcs   <= 1'b0;
         err_count_enable      <= 1'b0;
         err_count_hold        <= 1'b0;
         rdata                 <= 8'h00;
      end
      else
      begin
         module_laser_off      <= next_q.xcvr[`XCVR_LASER_OFF_BIT]; // RULE3
         rx_clock_mgr_run      <= next_q.enable[4]; // RULE5
         tx_clock_mgr_run      <= next_q.enable[1]; // RULE6
         line_iface_run        <= next_q.enable[0]; // RULE7
         link_established      <= next_q.st[8] & ~next_q.st[9]; // RULE8
         rx_buffer_source      <= next_q.framing[3:2];
         rx_fifo_enable        <= next_q.framing[3:2] == 2'b01; // RULE11
         rx_test_mode          <= next_q.framing[3]; // RULE11
         // raw stream passes unless gating is on and the link is down
         collect_gated         <= next_q.framing[1]
                                  & ~(next_q.st[8] & ~next_q.st[9]); // RULE12
         frame_sync_restart    <= next_q.framing[0]; // RULE13
         idle_filter_off       <= next_q.filter[3]; // RULE14
         rx_pattern_substitute <= next_q.testsrc[7]; // RULE15
         tx_debug_packets      <= next_q.testsrc[6]; // RULE16
         debug_payload         <= next_q.dbg_count; // RULE16
         ddr_fifo_to_tx        <= next_q.testsrc[5]; // RULE17
         tx_pattern_on         <= next_q.testsrc[3]; // RULE18
         tx_debug_source       <= next_q.testsrc[2:1];
         tx_debug_via_pcs      <= next_q.testsrc[2:1]
                                  == port_regs_pkg::TXSRC_DEBUG_PCS; // RULE19
         tx_debug_bypass_pcs   <= next_q.testsrc[2:1]
                                  == port_regs_pkg::TXSRC_DEBUG_NOPCS; // RULE19
         err_count_enable      <= next_q.cntctl[7]; // RULE20
         err_count_hold        <= next_q.cntctl[0]; // RULE21
         rdata                 <= next_q.rdata;
      end
   end

   // **************************************************
   // checks
   // **************************************************
   function automatic logic testsrc_held();
      testsrc_held = q.testsrc[6];
   endfunction : testsrc_held

   sequence write_seq(logic [7:0] a);
      wr && addr == a;
   endsequence

   sequence read_seq(logic [7:0] a);
      rd && addr == a;
   endsequence

   line_status_read_a: assert property ( // RULE1
      @(posedge sys_clk) disable iff (srst)
      read_seq(`LINE_IFACE_LOCK_STATUS_ADDR) |=> rdata[7:2] == 6'h00
      && rdata[1:0] == {$past(flt[0]), $past(flt[1])})
      else $error("line status read wrong");

   xcvr_status_read_a: assert property ( // RULE2
      @(posedge sys_clk) disable iff (srst)
      read_seq(`OPTICAL_MODULE_CTRL_STATUS_ADDR) |=> rdata[4:1] == 4'h0
      && rdata[7:5] == {$past(flt[2]), $past(flt[3]), $past(flt[4])})
      else $error("transceiver status read wrong");

   laser_off_a: assert property ( // RULE3
      @(posedge sys_clk) disable iff (srst)
      write_seq(`OPTICAL_MODULE_CTRL_STATUS_ADDR) |=>
      module_laser_off == $past(wdata[0]))
      else $error("laser off not following write");

   enable_read_a: assert property ( // RULE4
      @(posedge sys_clk) disable iff (srst)
      read_seq(`PORT_CLOCK_ENABLE_ADDR) |=> rdata[3:2] == 2'b00
      && rdata[7:5] == {$past(flt[5]), $past(flt[6]), $past(flt[7])})
      else $error("enable status read wrong");

   enable_run_a: assert property ( // RULE5 RULE6 RULE7
      @(posedge sys_clk) disable iff (srst)
      write_seq(`PORT_CLOCK_ENABLE_ADDR) |=>
      rx_clock_mgr_run == $past(wdata[4])
      && tx_clock_mgr_run == $past(wdata[1])
      && line_iface_run == $past(wdata[0]))
      else $error("enable bits not applied");

   link_good_a: assert property ( // RULE8
      @(posedge sys_clk) disable iff (srst)
      read_seq(`RX_FRAMING_CTRL_ADDR) |=>
      rdata[7] == (rdata[6] && !rdata[5]))
      else $error("link good mismatch");

   framing_read_a: assert property ( // RULE9 RULE10
      @(posedge sys_clk) disable iff (srst)
      read_seq(`RX_FRAMING_CTRL_ADDR) |=> rdata[6] == $past(flt[8])
      && rdata[5] == $past(flt[9]) && rdata[4] == 1'b0)
      else $error("framing status read wrong");

   rx_source_a: assert property ( // RULE11
      @(posedge sys_clk) disable iff (srst)
      write_seq(`RX_FRAMING_CTRL_ADDR) |=>
      rx_buffer_source == $past(wdata[3:2])
      && rx_fifo_enable == ($past(wdata[3:2]) == 2'b01)
      && rx_test_mode == $past(wdata[3]))
      else $error("receive source field not applied");

   // clearing the gate bit must not wait for the link
   collect_gate_a: assert property ( // RULE12
      @(posedge sys_clk) disable iff (srst)
      wr && addr == `RX_FRAMING_CTRL_ADDR && !wdata[1] |=> !collect_gated)
      else $error("collection still gated");

   restart_bit_a: assert property ( // RULE13
      @(posedge sys_clk) disable iff (srst)
      write_seq(`RX_FRAMING_CTRL_ADDR) |=>
      frame_sync_restart == $past(wdata[0]))
      else $error("sync restart bit not applied");

   filter_ctrl_a: assert property ( // RULE14
      @(posedge sys_clk) disable iff (srst)
      write_seq(`RX_FILTER_CTRL_ADDR) |=>
      idle_filter_off == $past(wdata[3]))
      else $error("idle filter bit not applied");

   test_source_a: assert property ( // RULE15 RULE16 RULE17 RULE18
      @(posedge sys_clk) disable iff (srst)
      write_seq(`TEST_SOURCE_SELECT_ADDR) |=>
      rx_pattern_substitute == $past(wdata[7])
      && tx_debug_packets == $past(wdata[6])
      && ddr_fifo_to_tx == $past(wdata[5])
      && tx_pattern_on == $past(wdata[3]))
      else $error("test source bits not applied");

   debug_wrap_a: assert property ( // RULE16
      @(posedge sys_clk) disable iff (srst)
      tx_debug_packets && debug_payload == `DEBUG_COUNT_LAST
      && testsrc_held() |=> debug_payload == `DEBUG_COUNT_FIRST)
      else $error("debug payload did not wrap");

   tx_debug_sel_a: assert property ( // RULE19
      @(posedge sys_clk) disable iff (srst)
      write_seq(`TEST_SOURCE_SELECT_ADDR) |=>
      tx_debug_source == $past(wdata[2:1])
      && tx_debug_via_pcs == ($past(wdata[2:1]) == 2'b01)
      && tx_debug_bypass_pcs == ($past(wdata[2:1]) == 2'b10))
      else $error("transmit debug source not applied");

   counter_ctrl_a: assert property ( // RULE20 RULE21
      @(posedge sys_clk) disable iff (srst)
      write_seq(`FRAME_COUNTER_CTRL_ADDR) |=>
      err_count_enable == $past(wdata[7])
      && err_count_hold == $past(wdata[0]))
      else $error("counter control not applied");

   status_wr_ignored_a: assert property ( // RULE22
      @(posedge sys_clk) disable iff (srst)
      write_seq(`LINE_IFACE_LOCK_STATUS_ADDR) ##2
      read_seq(`LINE_IFACE_LOCK_STATUS_ADDR) |=> rdata[7:2] == 6'h00)
      else $error("status write disturbed read");

endmodule : port_ctrl_status

//--- testbench/port_ctrl_status_tb.sv
// self-checking bench for the port 0 control and status register bank
// assumes the design and its constants header are compiled alongside
`include "port_regs_defs.svh"

`define CHK(got, exp) \
   begin \
      comparisons++; \
      if ((got) !== (exp)) \
      begin \
         mismatches++; \
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp); \
      end \
   end

module port_ctrl_status_tb;
   timeunit 1ns;
   timeprecision 100ps;

   // ****************************************
   // signals and instance
   // ****************************************
   logic       sys_clk = 1'b0;
   logic       srst    = 1'b1;
   logic [7:0] addr    = 8'h00;
   logic [7:0] wdata   = 8'h00;
   logic       wr      = 1'b0;
   logic       rd      = 1'b0;
   logic [9:0] st      = 10'h000;
   logic [7:0] rdata;
   logic       laser, rxrun, txrun, lrun, link, fifo_en, test_md, gated;
   logic       restart, idle_off, rx_sub, dbg_pkt, ddr_tx, prbs_on;
   logic       via_pcs, no_pcs, cnt_en, cnt_hold;
   logic [1:0] buf_src, dbg_src;
   logic [7:0] payload;
   int         mismatches  = 0;
   int         comparisons = 0;

   always #12.5 sys_clk = ~sys_clk;

   // status vector order: tx, rx, los, fault, pres, txl, rxl, sysl, sh, hber
   port_ctrl_status dut_u
   (
      .sys_clk(sys_clk), .srst(srst), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata),
      .line_tx_pll_locked(st[9]), .line_rx_pll_locked(st[8]),
      .module_signal_lost(st[7]), .module_fault(st[6]),
      .module_present(st[5]), .tx_clock_locked(st[4]),
      .rx_clock_locked(st[3]), .system_clock_locked(st[2]),
      .sync_header_locked(st[1]), .high_error_rate(st[0]),
      .module_laser_off(laser), .rx_clock_mgr_run(rxrun),
      .tx_clock_mgr_run(txrun), .line_iface_run(lrun),
      .link_established(link), .rx_buffer_source(buf_src),
      .rx_fifo_enable(fifo_en), .rx_test_mode(test_md),
      .collect_gated(gated), .frame_sync_restart(restart),
      .idle_filter_off(idle_off), .rx_pattern_substitute(rx_sub),
      .tx_debug_packets(dbg_pkt), .debug_payload(payload),
      .ddr_fifo_to_tx(ddr_tx), .tx_pattern_on(prbs_on),
      .tx_debug_source(dbg_src), .tx_debug_via_pcs(via_pcs),
      .tx_debug_bypass_pcs(no_pcs), .err_count_enable(cnt_en),
      .err_count_hold(cnt_hold)
   );

   // ****************************************
   // bus and status tasks
   // ****************************************
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      wr    <= 1'b1;
      addr  <= a;
      wdata <= d;
      @(posedge sys_clk);
      wr    <= 1'b0;
      #1;
   endtask : wr_reg

   // read data lives only in the cycle after the strobe, so sample there
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      @(posedge sys_clk);
      rd   <= 1'b1;
      addr <= a;
      @(posedge sys_clk);
      rd   <= 1'b0;
      #1;
      `CHK(rdata, e)
   endtask : rd_chk

   // the pins pass a 3-flop synchroniser, so allow a few cycles to settle
   task automatic set_st(input logic [9:0] v);
      @(posedge sys_clk);
      st <= v;
      repeat (8) @(posedge sys_clk);
      #1;
   endtask : set_st

   task automatic stop_test();
      $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : stop_test

   // ****************************************
   // scenarios
   // ****************************************
   task automatic test_rw();
      rd_chk(`OPTICAL_MODULE_CTRL_STATUS_ADDR, 8'h00);
      rd_chk(`FRAME_COUNTER_CTRL_ADDR, 8'h00);
      wr_reg(`LINE_IFACE_LOCK_STATUS_ADDR, 8'hFF);
      rd_chk(`LINE_IFACE_LOCK_STATUS_ADDR, 8'h00);
      wr_reg(`OPTICAL_MODULE_CTRL_STATUS_ADDR, 8'hFF);
      `CHK(laser, 1'b1)
      rd_chk(`OPTICAL_MODULE_CTRL_STATUS_ADDR, 8'h01);
      wr_reg(`PORT_CLOCK_ENABLE_ADDR, 8'hFF);
      `CHK({rxrun, txrun, lrun}, 3'b111)
      rd_chk(`PORT_CLOCK_ENABLE_ADDR, 8'h13);
      wr_reg(`RX_FILTER_CTRL_ADDR, 8'hFF);
      `CHK(idle_off, 1'b1)
      rd_chk(`RX_FILTER_CTRL_ADDR, 8'h08);
      wr_reg(`TEST_SOURCE_SELECT_ADDR, 8'hAF);
      `CHK({rx_sub, dbg_pkt, ddr_tx, prbs_on}, 4'b1011)
      `CHK(dbg_src, 2'b11)
      rd_chk(`TEST_SOURCE_SELECT_ADDR, 8'hAE);
      wr_reg(`FRAME_COUNTER_CTRL_ADDR, 8'h81);
      `CHK({cnt_en, cnt_hold}, 2'b11)
      wr_reg(`FRAME_COUNTER_CTRL_ADDR, 8'h7E);
      `CHK({cnt_en, cnt_hold}, 2'b00)
      rd_chk(`FRAME_COUNTER_CTRL_ADDR, 8'h00);
      wr_reg(`OPTICAL_MODULE_CTRL_STATUS_ADDR, 8'h00);
      `CHK(laser, 1'b0)
      wr_reg(`PORT_CLOCK_ENABLE_ADDR, 8'h10);
      `CHK({rxrun, txrun, lrun}, 3'b100)
      rd_chk(8'h82, 8'h00);
      $display("test_rw done");
   endtask : test_rw

   task automatic test_status();
      set_st(10'b10_101_101_10);
      rd_chk(`LINE_IFACE_LOCK_STATUS_ADDR, 8'h02);
      rd_chk(`OPTICAL_MODULE_CTRL_STATUS_ADDR, 8'hA0);
      rd_chk(`PORT_CLOCK_ENABLE_ADDR, 8'hB0);
      rd_chk(`RX_FRAMING_CTRL_ADDR, 8'hC0);
      `CHK(link, 1'b1)
      set_st(10'b01_010_010_01);
      rd_chk(`LINE_IFACE_LOCK_STATUS_ADDR, 8'h01);
      rd_chk(`OPTICAL_MODULE_CTRL_STATUS_ADDR, 8'h40);
      rd_chk(`PORT_CLOCK_ENABLE_ADDR, 8'h50);
      rd_chk(`RX_FRAMING_CTRL_ADDR, 8'h20);
      set_st(10'b00_000_000_11);
      rd_chk(`RX_FRAMING_CTRL_ADDR, 8'h60);
      `CHK(link, 1'b0)
      set_st(10'h000);
      $display("test_status done");
   endtask : test_status

   task automatic test_decode();
      logic [1:0] v;
      for (int i = 0; i < 4; i++)
      begin
         v = i[1:0];
         wr_reg(`RX_FRAMING_CTRL_ADDR, {4'h0, v, 2'b11});
         `CHK(buf_src, v)
         `CHK({fifo_en, test_md}, {v == 2'b01, v[1]})
         `CHK({gated, restart}, 2'b11)
         rd_chk(`RX_FRAMING_CTRL_ADDR, {4'h0, v, 2'b11});
         wr_reg(`TEST_SOURCE_SELECT_ADDR, {5'h00, v, 1'b1});
         `CHK(dbg_src, v)
         `CHK({via_pcs, no_pcs}, {v == 2'b01, v == 2'b10})
      end
      set_st(10'b00_000_000_10);
      `CHK(gated, 1'b0)
      wr_reg(`RX_FRAMING_CTRL_ADDR, 8'h00);
      `CHK({gated, restart}, 2'b00)
      set_st(10'h000);
      $display("test_decode done");
   endtask : test_decode

   // payload must step by one and fold from the last value back to zero
   task automatic test_debug();
      logic [7:0] prev;
      int         wraps;
      wraps = 0;
      wr_reg(`TEST_SOURCE_SELECT_ADDR, 8'h40);
      `CHK(dbg_pkt, 1'b1)
      prev = payload;
      for (int i = 0; i < 400 && wraps < 2; i++)
      begin
         @(posedge sys_clk);
         #1;
         if (prev == `DEBUG_COUNT_LAST)
         begin
            `CHK(payload, `DEBUG_COUNT_FIRST)
            wraps++;
         end
         else
            `CHK(payload, prev + 8'h01)
         prev = payload;
      end
      if (wraps < 2)
      begin
         mismatches++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, wraps, 2);
      end
      wr_reg(`TEST_SOURCE_SELECT_ADDR, 8'h00);
      `CHK(dbg_pkt, 1'b0)
      // the payload counter sees the cleared bit one clock later
      @(posedge sys_clk);
      #1;
      `CHK(payload, `DEBUG_COUNT_FIRST)
      $display("test_debug done");
   endtask : test_debug

   // a reset in mid-run must clear the stored controls
   task automatic test_reset();
      wr_reg(`PORT_CLOCK_ENABLE_ADDR, 8'h13);
      @(posedge sys_clk);
      srst <= 1'b1;
      repeat (2) @(posedge sys_clk);
      srst <= 1'b0;
      #1;
      `CHK({rxrun, txrun, lrun}, 3'b000)
      rd_chk(`PORT_CLOCK_ENABLE_ADDR, 8'h00);
      $display("test_reset done");
   endtask : test_reset

   // ****************************************
   // main sequence
   // ****************************************
   initial
   begin
      repeat (12) @(posedge sys_clk);
      srst <= 1'b0;
      test_rw();
      test_status();
      test_decode();
      test_debug();
      test_reset();
      stop_test();
   end
endmodule : port_ctrl_status_tb
